// ===== lpsc_pkg.sv
package lpsc_pkg;

    // ------------------------------------------------------------------
    // Register map (printed offsets are word indices, byte address = 4 x)
    // ------------------------------------------------------------------
    localparam int LPSC_ADR_W = 10;
    localparam logic [7:0] LPSC_IDX_CTRL = 8'h13;
    localparam logic [7:0] LPSC_IDX_DUTY = 8'h14;
    localparam logic [7:0] LPSC_IDX_MEM_FIRST = 8'h50;
    localparam logic [7:0] LPSC_IDX_MEM_LAST = 8'h67;
    localparam logic [7:0] LPSC_IDX_STATUS = 8'h70;

    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam int LPSC_CTRL_W = 3;
    localparam int LPSC_DUTY_W = 4;
    localparam int LPSC_CTRL_SHOW_BIT = 0;
    localparam int LPSC_CTRL_PSW_BIT = 1;
    localparam int LPSC_CTRL_WATCH_BIT = 2;
    localparam logic [2:0] LPSC_CTRL_RESET = 3'h0;
    localparam logic [3:0] LPSC_DUTY_RESET = 4'h0;
    localparam int LPSC_STAT_PHASE_LSB = 0;
    localparam int LPSC_STAT_GROUND_BIT = 2;
    localparam int LPSC_STAT_PSW_BIT = 3;

    // ------------------------------------------------------------------
    // Panel geometry
    // ------------------------------------------------------------------
    localparam int LPSC_COLUMNS = 24;
    localparam int LPSC_BACKPLANES = 4;
    localparam int LPSC_WORD_W = 4;
    localparam int LPSC_MEM_AW = 5;

    // ------------------------------------------------------------------
    // Display clock dividers, as counter masks on source edges
    // ------------------------------------------------------------------
    localparam logic [8:0] LPSC_OSC_MASK_64 = 9'h03f;
    localparam logic [8:0] LPSC_OSC_MASK_512 = 9'h1ff;
    localparam logic [11:0] LPSC_CYC_MASK_256 = 12'h0ff;
    localparam logic [11:0] LPSC_CYC_MASK_2048 = 12'h7ff;
    localparam logic [11:0] LPSC_CYC_MASK_4096 = 12'hfff;

    typedef enum logic [1:0] {
        LPSC_DUTY_QUARTER = 2'b00,
        LPSC_DUTY_THIRD = 2'b01,
        LPSC_DUTY_HALF = 2'b10,
        LPSC_DUTY_STATIC = 2'b11
    } lpsc_duty_t;

    typedef enum logic [1:0] {
        LPSC_CLK_OSC64 = 2'b00,
        LPSC_CLK_CYC256 = 2'b01,
        LPSC_CLK_CYC2048 = 2'b10,
        LPSC_CLK_FOURTH = 2'b11
    } lpsc_clksel_t;

    typedef enum logic [1:0] {
        LPSC_BUS_IDLE = 2'b00,
        LPSC_BUS_FETCH = 2'b01,
        LPSC_BUS_ACK = 2'b10
    } lpsc_bus_t;

endpackage

// ===== lpsc_dpram.sv
`timescale 1ns/1ps

// Two-port display memory: port a for software, port b for the scan.
module lpsc_dpram #(
    parameter int DEPTH = 24,
    parameter int WIDTH = 4,
    parameter int AW = 5
) (
    input wire logic clk_i,
    input wire logic a_we_i,
    input wire logic [AW-1:0] a_addr_i,
    input wire logic [WIDTH-1:0] a_wdata_i,
    output logic [WIDTH-1:0] a_rdata_o,
    input wire logic [AW-1:0] b_addr_i,
    output logic [WIDTH-1:0] b_rdata_o
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (a_we_i)
        begin
            mem[a_addr_i] <= a_wdata_i;
        end
        a_rdata_o <= mem[a_addr_i];
        b_rdata_o <= mem[b_addr_i];
    end

endmodule // lpsc_dpram

// ===== lpsc_scan.sv
`timescale 1ns/1ps

// What this block does
// - Drive 4 backplane and 24 column outputs
// - 24 words; word per column, bit per backplane
// - Memory writes reach columns via scan port
// - Control bit 0 low blanks all columns
// - Control bit 1 switches bias divider power
// - Low power, bit 2 low: ground all, switch off
// - Duty bits select quarter, third, half, static
// - Clock bits select osc/64, cycle/256, /2048, fourth
// - Fourth clock: cycle/4096 or osc/512 by timer bit
// - Oscillator clock keeps scan running when system stops
// - Cycle dividers use divided cycle clock input
module lpsc_scan
    import lpsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [LPSC_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Clock sources and power state
    input wire logic oscillator_clock_i,
    input wire logic divided_cycle_clock_i,
    input wire logic timer_source_select_bit_i,
    input wire logic low_power_mode_i,
    // Panel side
    output logic [LPSC_BACKPLANES-1:0] backplane_o,
    output logic [LPSC_COLUMNS-1:0] column_o,
    output logic power_switch_o
);

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    lpsc_bus_t bus_state_r;
    lpsc_bus_t bus_state_nxt;
    logic ack_r;
    logic [31:0] dat_r;
    logic [LPSC_CTRL_W-1:0] display_control_r;
    logic [LPSC_DUTY_W-1:0] display_duty_clock_select_r;

    wire logic bus_req = cyc_i & stb_i;
    wire logic [7:0] reg_idx = adr_i[LPSC_ADR_W-1:2];
    wire logic hit_ctrl = (reg_idx == LPSC_IDX_CTRL);
    wire logic hit_duty = (reg_idx == LPSC_IDX_DUTY);
    wire logic hit_status = (reg_idx == LPSC_IDX_STATUS);
    wire logic hit_mem = (reg_idx >= LPSC_IDX_MEM_FIRST) && (reg_idx <= LPSC_IDX_MEM_LAST);
    wire logic [7:0] mem_off = reg_idx - LPSC_IDX_MEM_FIRST;
    wire logic [LPSC_MEM_AW-1:0] mem_addr_a = mem_off[LPSC_MEM_AW-1:0];
    wire logic bus_commit = (bus_state_r == LPSC_BUS_FETCH) & bus_req;
    // A write lands on the edge at which the master samples ack high
    wire logic wr_commit = (bus_state_r == LPSC_BUS_ACK) & bus_req & we_i & sel_i[0];
    wire logic wr_ctrl = wr_commit & hit_ctrl;
    wire logic wr_duty = wr_commit & hit_duty;
    wire logic wr_mem = wr_commit & hit_mem;
    logic [LPSC_WORD_W-1:0] mem_rdata_a;
    logic [31:0] status_word;
    // Control registers are write-only and read back as zero
    wire logic [31:0] dat_nxt =
        hit_mem ? {28'h000_0000, mem_rdata_a} : (hit_status ? status_word : 32'h0000_0000);

    always_comb
    begin
        bus_state_nxt = LPSC_BUS_IDLE;
        case (bus_state_r)
            LPSC_BUS_IDLE: bus_state_nxt = bus_req ? LPSC_BUS_FETCH : LPSC_BUS_IDLE;
            LPSC_BUS_FETCH: bus_state_nxt = bus_req ? LPSC_BUS_ACK : LPSC_BUS_IDLE;
            default: bus_state_nxt = LPSC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_state_r <= LPSC_BUS_IDLE;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            display_control_r <= LPSC_CTRL_RESET;
            display_duty_clock_select_r <= LPSC_DUTY_RESET;
        end
        else
        begin
            bus_state_r <= bus_state_nxt;
            ack_r <= bus_commit;
            if (bus_commit && !we_i)
            begin
                dat_r <= dat_nxt;
            end
            if (wr_ctrl)
            begin
                display_control_r <= dat_i[LPSC_CTRL_W-1:0];
            end
            if (wr_duty)
            begin
                display_duty_clock_select_r <= dat_i[LPSC_DUTY_W-1:0];
            end
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // ------------------------------------------------------------------
    // Display memory
    // ------------------------------------------------------------------
    logic [LPSC_MEM_AW-1:0] scan_addr_r;
    logic [LPSC_MEM_AW-1:0] scan_addr_d_r;
    logic [LPSC_WORD_W-1:0] mem_rdata_b;

    lpsc_dpram #(
        .DEPTH(LPSC_COLUMNS),
        .WIDTH(LPSC_WORD_W),
        .AW(LPSC_MEM_AW)
    ) u_mem (
        .clk_i(clk_i),
        .a_we_i(wr_mem),
        .a_addr_i(mem_addr_a),
        .a_wdata_i(dat_i[LPSC_WORD_W-1:0]),
        .a_rdata_o(mem_rdata_a),
        .b_addr_i(scan_addr_r),
        .b_rdata_o(mem_rdata_b)
    );

    // ------------------------------------------------------------------
    // Source synchronisers and dividers
    // ------------------------------------------------------------------
    // Both sources come from pins, so each passes two flops before the
    // edge detector; the third flop only serves the edge compare.
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    logic cyc_s1_r;
    logic cyc_s2_r;
    logic cyc_s3_r;
    logic [8:0] osc_cnt_r;
    logic [11:0] cyc_cnt_r;

    wire logic osc_rise = osc_s2_r & ~osc_s3_r;
    wire logic cyc_rise = cyc_s2_r & ~cyc_s3_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
            cyc_s1_r <= 1'b0;
            cyc_s2_r <= 1'b0;
            cyc_s3_r <= 1'b0;
            osc_cnt_r <= 9'h000;
            cyc_cnt_r <= 12'h000;
        end
        else
        begin
            osc_s1_r <= oscillator_clock_i;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
            cyc_s1_r <= divided_cycle_clock_i;
            cyc_s2_r <= cyc_s1_r;
            cyc_s3_r <= cyc_s2_r;
            // Oscillator prescaler runs off its own edges only, so a stopped
            // cycle clock cannot stall it
            if (osc_rise)
            begin
                osc_cnt_r <= osc_cnt_r + 9'h001;
            end
            if (cyc_rise)
            begin
                cyc_cnt_r <= cyc_cnt_r + 12'h001;
            end
        end
    end

    wire logic oscillator_div64_clock = osc_rise & ((osc_cnt_r & LPSC_OSC_MASK_64) == LPSC_OSC_MASK_64);
    wire logic osc_div512_tick = osc_rise & (osc_cnt_r == LPSC_OSC_MASK_512);
    wire logic cycle_div256_clock = cyc_rise & ((cyc_cnt_r & LPSC_CYC_MASK_256) == LPSC_CYC_MASK_256);
    wire logic cycle_div2048_clock =
        cyc_rise & ((cyc_cnt_r & LPSC_CYC_MASK_2048) == LPSC_CYC_MASK_2048);
    wire logic cyc_div4096_tick = cyc_rise & (cyc_cnt_r == LPSC_CYC_MASK_4096);
    wire logic fourth_display_clock =
        timer_source_select_bit_i ? osc_div512_tick : cyc_div4096_tick;

    // ------------------------------------------------------------------
    // Display clock select and phase stepping
    // ------------------------------------------------------------------
    wire lpsc_clksel_t clk_sel = lpsc_clksel_t'(display_duty_clock_select_r[3:2]);
    wire lpsc_duty_t duty_sel = lpsc_duty_t'(display_duty_clock_select_r[1:0]);
    wire logic disp_tick =
        (clk_sel == LPSC_CLK_OSC64) ? oscillator_div64_clock :
        (clk_sel == LPSC_CLK_CYC256) ? cycle_div256_clock :
        (clk_sel == LPSC_CLK_CYC2048) ? cycle_div2048_clock :
        fourth_display_clock;
    wire logic [1:0] phase_last =
        (duty_sel == LPSC_DUTY_QUARTER) ? 2'h3 :
        (duty_sel == LPSC_DUTY_THIRD) ? 2'h2 :
        (duty_sel == LPSC_DUTY_HALF) ? 2'h1 :
        2'h0;

    logic [1:0] phase_r;
    logic [1:0] phase_nxt;

    // A duty change that leaves the phase out of range snaps it back at once
    always_comb
    begin
        phase_nxt = phase_r;
        if (phase_r > phase_last)
        begin
            phase_nxt = 2'h0;
        end
        else if (disp_tick)
        begin
            phase_nxt = (phase_r == phase_last) ? 2'h0 : phase_r + 2'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_r <= 2'h0;
        end
        else
        begin
            phase_r <= phase_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Memory scan into column shadow words
    // ------------------------------------------------------------------
    // The scan port sweeps all words continuously, so a new write shows
    // within one sweep of 24 clocks, far below any display period.
    wire logic scan_wrap = (scan_addr_r == LPSC_MEM_AW'(LPSC_COLUMNS - 1));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scan_addr_r <= '0;
            scan_addr_d_r <= '0;
        end
        else
        begin
            scan_addr_r <= scan_wrap ? '0 : scan_addr_r + LPSC_MEM_AW'(1);
            scan_addr_d_r <= scan_addr_r;
        end
    end

    // ------------------------------------------------------------------
    // Output gating
    // ------------------------------------------------------------------
    wire logic ground_all = low_power_mode_i & ~display_control_r[LPSC_CTRL_WATCH_BIT];
    wire logic show_cols = ~ground_all & display_control_r[LPSC_CTRL_SHOW_BIT];
    wire logic psw_nxt = ~ground_all & display_control_r[LPSC_CTRL_PSW_BIT];

    logic [LPSC_WORD_W-1:0] word_r [LPSC_COLUMNS];
    logic [LPSC_COLUMNS-1:0] column_r;
    logic [LPSC_BACKPLANES-1:0] backplane_r;
    logic psw_r;

    genvar gi;
    generate
        for (gi = 0; gi < LPSC_COLUMNS; gi++)
        begin : g_col
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    word_r[gi] <= '0;
                    column_r[gi] <= 1'b0;
                end
                else
                begin
                    if (scan_addr_d_r == LPSC_MEM_AW'(gi))
                    begin
                        word_r[gi] <= mem_rdata_b;
                    end
                    column_r[gi] <= show_cols & word_r[gi][phase_r];
                end
            end
        end
        for (gi = 0; gi < LPSC_BACKPLANES; gi++)
        begin : g_bp
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    backplane_r[gi] <= 1'b0;
                end
                else
                begin
                    backplane_r[gi] <= ~ground_all & (phase_r == 2'(gi));
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            psw_r <= 1'b0;
        end
        else
        begin
            psw_r <= psw_nxt;
        end
    end

    // is software's duty; here the watch bit is honoured whatever clock
    // is selected, which merely stalls if the cycle clock stops.
    assign backplane_o = backplane_r;
    assign column_o = column_r;
    assign power_switch_o = psw_r;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[LPSC_STAT_PHASE_LSB +: 2] = phase_r;
        status_word[LPSC_STAT_GROUND_BIT] = ground_all;
        status_word[LPSC_STAT_PSW_BIT] = psw_r;
    end

endmodule // lpsc_scan

// ===== lpsc_scan_monitor.sv
`timescale 1ns/1ps

module lpsc_scan_chk
    import lpsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [LPSC_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic low_power_mode_i,
    input wire logic [LPSC_BACKPLANES-1:0] backplane_o,
    input wire logic [LPSC_COLUMNS-1:0] column_o,
    input wire logic power_switch_o
);
    // ------------------------------------------------------------------
    // Shadow copies of the write-only registers, taken at the ack edge
    // ------------------------------------------------------------------
    logic [2:0] ctrl_r;
    logic [3:0] duty_r;
    wire logic [7:0] idx_w = adr_i[9:2];
    wire logic wr_w = ack_o && we_i && sel_i[0];
    wire logic mem_w = (idx_w >= LPSC_IDX_MEM_FIRST) && (idx_w <= LPSC_IDX_MEM_LAST);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_r <= 3'h0;
        else if (wr_w && idx_w == LPSC_IDX_CTRL)
            ctrl_r <= dat_i[2:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            duty_r <= 4'h0;
        else if (wr_w && idx_w == LPSC_IDX_DUTY)
            duty_r <= dat_i[3:0];
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    property p_ack_latency;
        ack_o |-> cyc_i && stb_i && $past(cyc_i && stb_i) && $past(cyc_i && stb_i, 2);
    endproperty
    property p_read_zero;
        ack_o && !we_i && !mem_w && idx_w != LPSC_IDX_STATUS |-> dat_o == 32'h0;
    endproperty
    property p_onehot; $onehot0(backplane_o); endproperty
    // Three samples cover the register commit plus the output stage
    property p_ground;
        (low_power_mode_i && !ctrl_r[2])[*3] |->
            backplane_o == 4'h0 && column_o == 24'h0 && !power_switch_o;
    endproperty
    property p_switch_on;
        (!low_power_mode_i && ctrl_r[1])[*3] |-> power_switch_o;
    endproperty
    property p_switch_off; (!ctrl_r[1])[*3] |-> !power_switch_o; endproperty
    property p_blank; (!ctrl_r[0])[*3] |-> column_o == 24'h0; endproperty
    property p_duty;
        $stable(duty_r)[*3] |-> {1'b0, backplane_o} < (5'h01 << (3'h4 - {1'b0, duty_r[1:0]}));
    endproperty

    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_latency: assert property (p_ack_latency) else $error("ack without held request");
    a_read_zero: assert property (p_read_zero) else $error("nonzero read data");
    a_onehot: assert property (p_onehot) else $error("several backplanes active");
    a_ground: assert property (p_ground) else $error("outputs not grounded");
    a_switch_on: assert property (p_switch_on) else $error("power switch stays off");
    a_switch_off: assert property (p_switch_off) else $error("power switch stays on");
    a_blank: assert property (p_blank) else $error("columns not blanked");
    a_duty: assert property (p_duty) else $error("backplane beyond duty");

    c_read: cover property (ack_o && !we_i);
    c_watch: cover property (low_power_mode_i && ctrl_r[2] && backplane_o != 4'h0);
    c_static: cover property (duty_r[1:0] == 2'b11 && backplane_o == 4'h1);
endmodule // lpsc_scan_chk

bind lpsc_scan lpsc_scan_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .low_power_mode_i(low_power_mode_i), .backplane_o(backplane_o),
    .column_o(column_o), .power_switch_o(power_switch_o));

// ===== lpsc_panel_model.sv
`timescale 1ns/1ps

// Passive panel: remembers the last column pattern seen under each backplane
module lpsc_panel_model (
    input wire logic clk_i,
    input wire logic clear_i,
    input wire logic [3:0] backplane_i,
    input wire logic [23:0] column_i,
    output logic [3:0] seen_o,
    output logic [15:0] steps_o,
    output logic [3:0][23:0] frame_o
);
    logic [3:0] last_r;

    always @(posedge clk_i)
    begin
        last_r <= backplane_i;
        if (clear_i)
        begin
            seen_o <= 4'h0;
            steps_o <= 16'h0;
        end
        else
        begin
            seen_o <= seen_o | backplane_i;
            if (backplane_i != last_r)
                steps_o <= steps_o + 16'h1;
        end
        for (int b = 0; b < 4; b++)
            if (backplane_i[b])
                frame_o[b] <= column_i;
    end
endmodule // lpsc_panel_model

// ===== testbench.sv
`timescale 1ns/1ps

module testbench
    import lpsc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i, cyc_i, stb_i, we_i, ack_o, osc, cyc_clk, tmr, low_pwr, psw, cyc_run, clear;
    logic [LPSC_ADR_W-1:0] adr_i;
    logic [3:0] sel_i, bp, seen;
    logic [31:0] dat_i, dat_o;
    logic [23:0] col;
    logic [15:0] steps;
    logic [3:0][23:0] frame;
    logic [3:0] mem [24];
    logic [31:0] rq [$];
    logic [31:0] seed = 32'h22;
    int mismatches = 0;
    int num_checks = 0;

    lpsc_scan DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .oscillator_clock_i(osc), .divided_cycle_clock_i(cyc_clk),
        .timer_source_select_bit_i(tmr), .low_power_mode_i(low_pwr),
        .backplane_o(bp), .column_o(col), .power_switch_o(psw));
    lpsc_panel_model u_panel (.clk_i(clk_i), .clear_i(clear), .backplane_i(bp),
        .column_i(col), .seen_o(seen), .steps_o(steps), .frame_o(frame));

    // ------------------------------------------------------------------
    // Clocks: sources run fast so divider counts stay short in time
    // ------------------------------------------------------------------
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (cyc_run) cyc_clk <= ~cyc_clk;
    always begin repeat (2) @(posedge clk_i); osc <= ~osc; end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        num_checks++;
        if (seen_v !== exp_v)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    // Read data is compared by this watcher, against notes left by the driver
    always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, rq.pop_front());

    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= d;
        sel_i <= s;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, 4'hf);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, idx, rnd(), 4'hf);
    endtask

    task automatic clr();
        clear <= 1'b1;
        // Two clearing edges let a phase snap after a duty write settle first
        repeat (2) @(posedge clk_i);
        clear <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wsteps(input int n);
        int i;
        logic [15:0] b;
        i = 0;
        b = steps;
        while (steps - b < 16'(n) && i < 20000) begin @(posedge clk_i); i++; end
    endtask

    task automatic fcheck(input int nbp);
        logic [23:0] e;
        for (int b = 0; b < nbp; b++)
        begin
            for (int k = 0; k < 24; k++) e[k] = mem[k][b];
            chk(32'(frame[b]), 32'(e));
        end
    endtask

    // Tick spacing in clk cycles, measured between two backplane steps
    task automatic meas(input int p);
        int n;
        logic [3:0] last;
        n = 0;
        last = bp;
        while (bp === last && n < 3 * p) begin @(posedge clk_i); n++; end
        n = 0;
        last = bp;
        while (bp === last && n < 3 * p) begin @(posedge clk_i); n++; end
        chk(32'(n), 32'(p));
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin repeat (60000) @(posedge clk_i); mismatches++; conclude(); end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [31:0] r;
        int sel [5];
        int per [5];
        sel = '{0, 1, 2, 3, 3};
        per = '{256, 512, 4096, 2048, 8192};
        {cyc_i, stb_i, we_i, osc, cyc_clk, tmr, low_pwr, clear} = 8'h0;
        adr_i = '0;
        sel_i = 4'h0;
        dat_i = 32'h0;
        cyc_run = 1'b1;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(LPSC_IDX_CTRL, 32'h0);
        rd(LPSC_IDX_DUTY, 32'h0);
        rd(8'h00, 32'h0);
        rd(LPSC_IDX_STATUS, 32'h0);
        for (int k = 0; k < 24; k++)
        begin
            r = rnd();
            mem[k] = r[3:0];
            wr(LPSC_IDX_MEM_FIRST + 8'(k), {r[31:4], mem[k]});
        end
        // Lane 0 not selected: the word must keep its old value
        bus(1'b1, LPSC_IDX_MEM_FIRST, {28'h0, ~mem[0]}, 4'he);
        for (int k = 0; k < 24; k++) rd(LPSC_IDX_MEM_FIRST + 8'(k), {28'h0, mem[k]});
        wr(LPSC_IDX_DUTY, 32'h0);
        wr(LPSC_IDX_CTRL, 32'h3);
        clr();
        wsteps(5);
        fcheck(4);
        chk(32'(seen), 32'hf);
        chk(32'(psw), 32'h1);
        mem[5] = ~mem[5];
        wr(LPSC_IDX_MEM_FIRST + 8'h05, {28'h0, mem[5]});
        wsteps(5);
        fcheck(4);
        for (int d = 0; d < 4; d++)
        begin
            wr(LPSC_IDX_DUTY, 32'(d));
            clr();
            repeat (1800) @(posedge clk_i);
            chk(32'(seen), (32'h1 << (4 - d)) - 32'h1);
            fcheck(4 - d);
        end
        for (int i = 0; i < 5; i++)
        begin
            tmr <= (i == 3);
            wr(LPSC_IDX_DUTY, 32'(sel[i] << 2));
            meas(per[i]);
        end
        wr(LPSC_IDX_DUTY, 32'h0);
        wr(LPSC_IDX_CTRL, 32'h2);
        repeat (300) @(posedge clk_i);
        chk(32'(col), 32'h0);
        chk(32'(psw), 32'h1);
        wr(LPSC_IDX_CTRL, 32'h1);
        repeat (4) @(posedge clk_i);
        chk(32'(psw), 32'h0);
        low_pwr <= 1'b1;
        wr(LPSC_IDX_CTRL, 32'h3);
        repeat (4) @(posedge clk_i);
        chk({bp, col, psw}, 32'h0);
        // Oscillator clock stays selected before watch display is enabled
        wr(LPSC_IDX_CTRL, 32'h7);
        cyc_run <= 1'b0;
        clr();
        wsteps(3);
        chk(32'(steps >= 16'h3), 32'h1);
        chk(32'(psw), 32'h1);
        low_pwr <= 1'b0;
        cyc_run <= 1'b1;
        conclude();
    end
endmodule // testbench
